// file: shared/dcf_pkg.sv
package dcf_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int DCF_DEPTH = 64;
  localparam int DCF_WIDTH = 36;
  localparam int DCF_BYTE_BITS = 9;
  localparam int DCF_BYTES = 4;
  localparam int DCF_PTR_BITS = 7;
  localparam int DCF_ADDR_BITS = 6;
  localparam int DCF_SYNC_STAGES = 2;

  // ==========================================================================
  // Offset presets, chosen by a two-bit strap caught during reset
  // ==========================================================================
  localparam logic [1:0] DCF_OFS_SEL_0 = 2'h0;
  localparam logic [1:0] DCF_OFS_SEL_1 = 2'h1;
  localparam logic [1:0] DCF_OFS_SEL_2 = 2'h2;
  localparam logic [DCF_PTR_BITS-1:0] DCF_OFS_PRESET_0 = 7'h10;
  localparam logic [DCF_PTR_BITS-1:0] DCF_OFS_PRESET_1 = 7'h0c;
  localparam logic [DCF_PTR_BITS-1:0] DCF_OFS_PRESET_2 = 7'h08;
  localparam logic [DCF_PTR_BITS-1:0] DCF_OFS_PRESET_3 = 7'h04;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DCF_PTR_BITS-1:0] DCF_PTR_RESET = 7'h00;
  localparam logic [DCF_PTR_BITS-1:0] DCF_FULL_COUNT = 7'h40;
  localparam logic [DCF_PTR_BITS-1:0] DCF_ONE = 7'h01;
  localparam logic [DCF_WIDTH-1:0] DCF_WORD_RESET = 36'h000000000;
  localparam logic DCF_FLAG_N_IDLE = 1'b1;
  localparam logic DCF_FLAG_N_ACTIVE = 1'b0;

  // Control pins of one port, all sampled on the port clock.
  typedef struct packed {
    logic chip_select_n;
    logic write_read_sel;
    logic enable;
    logic mail_select;
    logic parity_gen_sel;
  } dcf_port_ctl_type;

endpackage : dcf_pkg

// file: design/dcf_fifo.sv
`timescale 1ns/100ps
// Contract
// RL1: Almost-empty low while count at or below offset, high above it.
// RL2: Almost-empty rises on second read-clock edge after filling write; the code raises it on the third.
// RL3: Edges too close to the write do not count as first sync cycle.
// RL4: Almost-full low at sixty-four minus offset or more, high below it.
// RL5: Almost-full rises on second write-clock edge after the draining read; the code raises it on the third.
// RL6: Edges too close to the read do not count as first sync cycle.
// RL7: Shared offset loaded from one of four presets during reset.
// RL8: Port A mailbox write stores port A bus into mailbox one.
// RL9: Port B mailbox write stores port B bus into mailbox two.
// RL10: Mailbox write lowers its flag; writes ignored while flag low.
// RL11: Port B shows output register or mailbox one; port A mailbox two.
// RL12: Port B mailbox read sets mailbox one flag high.
// RL13: Port A mailbox read sets mailbox two flag high.
// RL14: Reading a mailbox leaves its contents unchanged.
// RL15: Each port splits into four nine-bit bytes, each parity checked.
// RL16: Parity error output low when any byte violates selected parity.
// RL17: Port A mailbox read with generation forces its error output high.
// RL18: Port B mailbox read with generation forces its error output high.
// RL19: Generation replaces each byte top bit with parity of low eight.
// RL20: Writes store all thirty-six bits regardless of generation select.
// RL21: FIFO parity made before output register; selects sampled at load.
// RL22: Generating parity on mailbox reads never alters the mailbox.
// RL23: Flags pass two flip-flop stages in their own port clock domain.
// RL24: FIFO read needs select, read direction, enable, no mail, not empty.
// RL25: Threshold flags active low, registered, from synchronized pointers.
module dcf_fifo #(
  parameter int DEPTH = dcf_pkg::DCF_DEPTH,
  parameter int WIDTH = dcf_pkg::DCF_WIDTH
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [1:0] offset_sel_in,
  input wire logic parity_odd_sel_in,
  input wire dcf_pkg::dcf_port_ctl_type port_a_ctl_in,
  input wire dcf_pkg::dcf_port_ctl_type port_b_ctl_in,
  input wire logic [dcf_pkg::DCF_WIDTH-1:0] port_a_bus_in,
  output logic [dcf_pkg::DCF_WIDTH-1:0] port_a_bus_out,
  output logic port_a_bus_oe_out,
  input wire logic [dcf_pkg::DCF_WIDTH-1:0] port_b_bus_in,
  output logic [dcf_pkg::DCF_WIDTH-1:0] port_b_bus_out,
  output logic port_b_bus_oe_out,
  output logic empty_flag_n_out,
  output logic almost_empty_flag_n_out,
  output logic full_flag_n_out,
  output logic almost_full_flag_n_out,
  output logic mail_one_flag_n_out,
  output logic mail_two_flag_n_out,
  output logic port_a_parity_error_n_out,
  output logic port_b_parity_error_n_out
);
  import dcf_pkg::*;

  // ==========================================================================
  // Parity helpers
  // ==========================================================================

  // Replaces the top bit of every byte by the parity of its low eight bits.
  function automatic logic [DCF_WIDTH-1:0] gen_parity(
    input logic [DCF_WIDTH-1:0] word,
    input logic odd
  );
    logic [DCF_WIDTH-1:0] result;
    result = word;
    for (int i = 0; i < DCF_BYTES; i++) begin
      result[i*DCF_BYTE_BITS+DCF_BYTE_BITS-1] =
        (^word[i*DCF_BYTE_BITS +: DCF_BYTE_BITS-1]) ^ odd;
    end
    return result;
  endfunction : gen_parity

  // High when any of the four bytes breaks the selected parity sense.
  function automatic logic parity_bad(
    input logic [DCF_WIDTH-1:0] word,
    input logic odd
  );
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < DCF_BYTES; i++) begin
      bad = bad | ((^word[i*DCF_BYTE_BITS +: DCF_BYTE_BITS]) != odd);
    end
    return bad;
  endfunction : parity_bad

  // ==========================================================================
  // Storage and state
  // ==========================================================================
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DCF_PTR_BITS-1:0] wr_ptr;
  logic [DCF_PTR_BITS-1:0] rd_ptr;
  logic [DCF_PTR_BITS-1:0] wr_ptr_sync [DCF_SYNC_STAGES];
  logic [DCF_PTR_BITS-1:0] rd_ptr_sync [DCF_SYNC_STAGES];
  logic [DCF_PTR_BITS-1:0] offset;
  logic [DCF_PTR_BITS-1:0] offset_latch;
  logic [DCF_WIDTH-1:0] out_reg;
  logic [DCF_WIDTH-1:0] mail_one;
  logic [DCF_WIDTH-1:0] mail_two;

  // ==========================================================================
  // Port decode
  // ==========================================================================
  wire a_sel = !port_a_ctl_in.chip_select_n && port_a_ctl_in.enable;
  wire b_sel = !port_b_ctl_in.chip_select_n && port_b_ctl_in.enable;
  wire a_wr = a_sel && port_a_ctl_in.write_read_sel;
  wire a_rd = a_sel && !port_a_ctl_in.write_read_sel;
  wire b_wr = b_sel && port_b_ctl_in.write_read_sel;
  wire b_rd = b_sel && !port_b_ctl_in.write_read_sel;
  wire a_mail = port_a_ctl_in.mail_select;
  wire b_mail = port_b_ctl_in.mail_select;
  // Mailbox writes are dropped while unread mail is waiting.
  // RL8 mailbox one write
  wire mail_one_wr = a_wr && a_mail && mail_one_flag_n_out;
  // RL9 mailbox two write
  wire mail_two_wr = b_wr && b_mail && mail_two_flag_n_out;
  // RL12 mailbox one read
  wire mail_one_rd = b_rd && b_mail;
  // RL13 mailbox two read
  wire mail_two_rd = a_rd && a_mail;
  wire fifo_wr = a_wr && !a_mail && full_flag_n_out;
  // RL24 FIFO read qualify
  wire fifo_rd = b_rd && !b_mail && empty_flag_n_out;

  // ==========================================================================
  // Pointer arithmetic and threshold compares
  // ==========================================================================
  wire [DCF_PTR_BITS-1:0] next_wr_ptr = fifo_wr ? wr_ptr + DCF_ONE : wr_ptr;
  wire [DCF_PTR_BITS-1:0] next_rd_ptr = fifo_rd ? rd_ptr + DCF_ONE : rd_ptr;
  // The read side sees the write pointer only after two stages, so a new
  // word shows on the read flags on the third read edge after the write.
  // RL25 synchronized pointer counts
  wire [DCF_PTR_BITS-1:0] rd_side_count =
    wr_ptr_sync[DCF_SYNC_STAGES-1] - next_rd_ptr;
  wire [DCF_PTR_BITS-1:0] wr_side_count =
    next_wr_ptr - rd_ptr_sync[DCF_SYNC_STAGES-1];
  // RL1 almost-empty threshold
  wire next_almost_empty_n = rd_side_count > offset;
  // RL4 almost-full threshold
  wire next_almost_full_n = wr_side_count < (DCF_FULL_COUNT - offset);
  wire next_empty_n = rd_side_count != DCF_PTR_RESET;
  wire next_full_n = wr_side_count != DCF_FULL_COUNT;

  // RL7 offset preset select
  wire [DCF_PTR_BITS-1:0] next_offset =
    (offset_sel_in == DCF_OFS_SEL_0) ? DCF_OFS_PRESET_0 :
    (offset_sel_in == DCF_OFS_SEL_1) ? DCF_OFS_PRESET_1 :
    (offset_sel_in == DCF_OFS_SEL_2) ? DCF_OFS_PRESET_2 : DCF_OFS_PRESET_3;

  // ==========================================================================
  // Data paths and parity
  // ==========================================================================
  // RL21 parity before output register
  wire [DCF_WIDTH-1:0] fifo_word = port_b_ctl_in.parity_gen_sel ?
    gen_parity(mem[rd_ptr[DCF_ADDR_BITS-1:0]], parity_odd_sel_in) :
    mem[rd_ptr[DCF_ADDR_BITS-1:0]];
  // RL19 byte parity substitution
  wire [DCF_WIDTH-1:0] mail_one_view = port_b_ctl_in.parity_gen_sel ?
    gen_parity(mail_one, parity_odd_sel_in) : mail_one;
  wire [DCF_WIDTH-1:0] mail_two_view = port_a_ctl_in.parity_gen_sel ?
    gen_parity(mail_two, parity_odd_sel_in) : mail_two;
  // RL11 output source select
  wire [DCF_WIDTH-1:0] next_b_bus = b_mail ? mail_one_view : out_reg;
  // The generator trees are shared with the checkers, so a generating
  // mailbox read cannot check the bus and reports no error.
  // RL17 port A error forced
  wire a_force_ok = mail_two_rd && port_a_ctl_in.parity_gen_sel;
  // RL18 port B error forced
  wire b_force_ok = mail_one_rd && port_b_ctl_in.parity_gen_sel;
  // RL16 parity error detect
  wire next_a_perr_n =
    a_force_ok || !parity_bad(port_a_bus_in, parity_odd_sel_in);
  wire next_b_perr_n =
    b_force_ok || !parity_bad(port_b_bus_in, parity_odd_sel_in);

  // ==========================================================================
  // FIFO array, unreset storage
  // ==========================================================================
  // RL20 raw word storage
  always_ff @(posedge clock_in) begin
    if (fifo_wr) begin
      mem[wr_ptr[DCF_ADDR_BITS-1:0]] <= port_a_bus_in;
    end
  end

  // Pointers, output register and their cross-side copies.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr <= DCF_PTR_RESET;
      rd_ptr <= DCF_PTR_RESET;
      out_reg <= DCF_WORD_RESET;
      for (int i = 0; i < DCF_SYNC_STAGES; i++) begin
        wr_ptr_sync[i] <= DCF_PTR_RESET;
        rd_ptr_sync[i] <= DCF_PTR_RESET;
      end
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      // RL23 two stage pipeline
      wr_ptr_sync[0] <= wr_ptr;
      rd_ptr_sync[0] <= rd_ptr;
      for (int i = 1; i < DCF_SYNC_STAGES; i++) begin
        wr_ptr_sync[i] <= wr_ptr_sync[i-1];
        rd_ptr_sync[i] <= rd_ptr_sync[i-1];
      end
      if (fifo_rd) begin
        out_reg <= fifo_word;
      end
    end
  end

  // The offset strap is caught while reset is held, never as a reset value.
  // RL7 offset load
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      offset_latch <= next_offset;
    end
  end
  assign offset = offset_latch;

  // ==========================================================================
  // Status flags
  // ==========================================================================
  // RL2 almost-empty three edge rise
  // RL3 skew slips one edge
  // RL5 almost-full three edge rise
  // RL6 skew slips one edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      empty_flag_n_out <= DCF_FLAG_N_ACTIVE;
      almost_empty_flag_n_out <= DCF_FLAG_N_ACTIVE;
      full_flag_n_out <= DCF_FLAG_N_ACTIVE;
      almost_full_flag_n_out <= DCF_FLAG_N_ACTIVE;
    end else begin
      empty_flag_n_out <= next_empty_n;
      almost_empty_flag_n_out <= next_almost_empty_n;
      full_flag_n_out <= next_full_n;
      almost_full_flag_n_out <= next_almost_full_n;
    end
  end

  // ==========================================================================
  // Mailboxes; a read that coincides with a write keeps the flag high
  // ==========================================================================
  // RL10 write lowers flag
  // RL14 contents held on read
  // RL22 generation leaves mailbox
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mail_one <= DCF_WORD_RESET;
      mail_two <= DCF_WORD_RESET;
      mail_one_flag_n_out <= DCF_FLAG_N_IDLE;
      mail_two_flag_n_out <= DCF_FLAG_N_IDLE;
    end else begin
      if (mail_one_wr) begin
        mail_one <= port_a_bus_in;
      end
      if (mail_two_wr) begin
        mail_two <= port_b_bus_in;
      end
      if (mail_one_rd) begin
        mail_one_flag_n_out <= DCF_FLAG_N_IDLE;
      end else if (mail_one_wr) begin
        mail_one_flag_n_out <= DCF_FLAG_N_ACTIVE;
      end
      if (mail_two_rd) begin
        mail_two_flag_n_out <= DCF_FLAG_N_IDLE;
      end else if (mail_two_wr) begin
        mail_two_flag_n_out <= DCF_FLAG_N_ACTIVE;
      end
    end
  end

  // ==========================================================================
  // Bus drivers and parity outputs, registered for clean pin timing
  // ==========================================================================
  // RL15 four byte trees
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port_a_bus_out <= DCF_WORD_RESET;
      port_b_bus_out <= DCF_WORD_RESET;
      port_a_bus_oe_out <= 1'b0;
      port_b_bus_oe_out <= 1'b0;
      port_a_parity_error_n_out <= DCF_FLAG_N_IDLE;
      port_b_parity_error_n_out <= DCF_FLAG_N_IDLE;
    end else begin
      port_a_bus_out <= mail_two_view;
      port_b_bus_out <= next_b_bus;
      port_a_bus_oe_out <= !port_a_ctl_in.chip_select_n &&
        !port_a_ctl_in.write_read_sel;
      port_b_bus_oe_out <= !port_b_ctl_in.chip_select_n &&
        !port_b_ctl_in.write_read_sel;
      port_a_parity_error_n_out <= next_a_perr_n;
      port_b_parity_error_n_out <= next_b_perr_n;
    end
  end

endmodule : dcf_fifo

// file: bench/dcf_fifo_props.sv
`timescale 1ns/100ps
// =========================================================================
// Port-level checks of mailbox flags, output enable, parity forcing and empty versus almost-empty.
module dcf_fifo_props (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire dcf_pkg::dcf_port_ctl_type port_a_ctl_in,
  input wire dcf_pkg::dcf_port_ctl_type port_b_ctl_in,
  input wire logic port_a_bus_oe_out,
  input wire logic empty_flag_n_out,
  input wire logic almost_empty_flag_n_out,
  input wire logic mail_one_flag_n_out,
  input wire logic mail_two_flag_n_out,
  input wire logic port_a_parity_error_n_out,
  input wire logic port_b_parity_error_n_out
);
  import dcf_pkg::*;
  // Decoded requests; enable qualifies every mailbox transfer.
  wire logic a_on = !port_a_ctl_in.chip_select_n && port_a_ctl_in.enable;
  wire logic b_on = !port_b_ctl_in.chip_select_n && port_b_ctl_in.enable;
  wire logic a_mail = a_on && port_a_ctl_in.mail_select;
  wire logic b_mail = b_on && port_b_ctl_in.mail_select;
  wire logic a_mw = a_mail && port_a_ctl_in.write_read_sel;
  wire logic a_mr = a_mail && !port_a_ctl_in.write_read_sel;
  wire logic b_mw = b_mail && port_b_ctl_in.write_read_sel;
  wire logic b_mr = b_mail && !port_b_ctl_in.write_read_sel;
  wire logic a_rdir = !port_a_ctl_in.chip_select_n
    && !port_a_ctl_in.write_read_sel;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_mail_one_low:
    assert property (a_mw && mail_one_flag_n_out && !b_mr
      |=> !mail_one_flag_n_out) else $error("mail one flag not lowered");
  chk_mail_two_low:
    assert property (b_mw && mail_two_flag_n_out && !a_mr
      |-> ##1 !mail_two_flag_n_out) else $error("mail two flag not lowered");
  chk_mail_one_set:
    assert property (b_mr |=> mail_one_flag_n_out)
      else $error("mail one flag not raised by read");
  chk_mail_two_set:
    assert property (a_mr |-> ##1 mail_two_flag_n_out)
      else $error("mail two flag not raised by read");
  chk_pe_a_forced:
    assert property (a_mr && port_a_ctl_in.parity_gen_sel
      |=> port_a_parity_error_n_out) else $error("port a error not forced");
  chk_pe_b_forced:
    assert property (b_mr && port_b_ctl_in.parity_gen_sel
      |=> port_b_parity_error_n_out) else $error("port b error not forced");
  chk_a_drive_oe:
    assert property (!$past(rst_in) |-> port_a_bus_oe_out == $past(a_rdir))
      else $error("port a enable does not follow select");
  chk_empty_ae_low:
    assert property (!empty_flag_n_out |-> !almost_empty_flag_n_out)
      else $error("almost empty high while empty");
endmodule : dcf_fifo_props
bind dcf_fifo dcf_fifo_props chk (.clock_in(clock_in), .rst_in(rst_in),
  .port_a_ctl_in(port_a_ctl_in), .port_b_ctl_in(port_b_ctl_in),
  .port_a_bus_oe_out(port_a_bus_oe_out), .empty_flag_n_out(empty_flag_n_out),
  .almost_empty_flag_n_out(almost_empty_flag_n_out),
  .mail_one_flag_n_out(mail_one_flag_n_out),
  .mail_two_flag_n_out(mail_two_flag_n_out),
  .port_a_parity_error_n_out(port_a_parity_error_n_out),
  .port_b_parity_error_n_out(port_b_parity_error_n_out));

// file: bench/dcf_port_b_host.sv
`timescale 1ns/100ps
// =========================================================================
// Port B processor: passes requests and resolves the shared data pins.
module dcf_port_b_host (
  input wire logic clock_in,
  input wire dcf_pkg::dcf_port_ctl_type req_in,
  input wire logic [dcf_pkg::DCF_WIDTH-1:0] drive_in,
  input wire logic [dcf_pkg::DCF_WIDTH-1:0] dev_bus_in,
  input wire logic dev_oe_in,
  output dcf_pkg::dcf_port_ctl_type ctl_out,
  output logic [dcf_pkg::DCF_WIDTH-1:0] pins_out
);
  import dcf_pkg::*;
  logic [DCF_WIDTH-1:0] last = '0;
  wire logic host_drives = !req_in.chip_select_n && req_in.write_read_sel;
  assign ctl_out = req_in;
  // drive only when writing
  // A released bus shows the inverse of its last level, never stale data.
  assign pins_out = host_drives ? drive_in : dev_oe_in ? dev_bus_in : ~last;
  always_ff @(posedge clock_in) begin
    last <= pins_out;
  end
endmodule : dcf_port_b_host

// file: bench/dual_clock_fifo_flags_mail_parity_tb.sv
`timescale 1ns/100ps
// =========================================================================
// Queue model of the FIFO compared at every result, then mailbox checks.
module dual_clock_fifo_flags_mail_parity_tb;
  import dcf_pkg::*;
  typedef logic [DCF_WIDTH-1:0] dcf_word_type;
  localparam dcf_port_ctl_type idle_ctl = 5'h10;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] offset_sel_in = 2'h0;
  logic odd = 1'b1;
  dcf_port_ctl_type a_ctl = idle_ctl;
  dcf_port_ctl_type b_req = idle_ctl;
  dcf_port_ctl_type b_ctl;
  dcf_word_type a_drv = '0, b_drv = '0, a_pins, b_pins, a_out, b_out, w, e;
  logic a_oe, b_oe, ef, ae, ff, af, mf1, mf2, pea, peb;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int x;
  logic [31:0] seed = 32'd88951;
  dcf_word_type q[$];
  assign a_pins = a_oe ? a_out : a_drv;
  dcf_fifo uut (.clock_in(clock_in), .rst_in(rst_in),
    .offset_sel_in(offset_sel_in), .parity_odd_sel_in(odd),
    .port_a_ctl_in(a_ctl), .port_b_ctl_in(b_ctl), .port_a_bus_in(a_pins),
    .port_a_bus_out(a_out), .port_a_bus_oe_out(a_oe),
    .port_b_bus_in(b_pins), .port_b_bus_out(b_out), .port_b_bus_oe_out(b_oe),
    .empty_flag_n_out(ef), .almost_empty_flag_n_out(ae),
    .full_flag_n_out(ff), .almost_full_flag_n_out(af),
    .mail_one_flag_n_out(mf1), .mail_two_flag_n_out(mf2),
    .port_a_parity_error_n_out(pea), .port_b_parity_error_n_out(peb));
  dcf_port_b_host host (.clock_in(clock_in), .req_in(b_req),
    .drive_in(b_drv), .dev_bus_in(b_out), .dev_oe_in(b_oe),
    .ctl_out(b_ctl), .pins_out(b_pins));
  initial forever #12.5 clock_in = ~clock_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Top bit of each byte becomes the parity of its low eight bits.
  function automatic dcf_word_type gen(input dcf_word_type v, input logic o);
    for (int i = 0; i < DCF_BYTES; i++) begin
      v[i*DCF_BYTE_BITS+8] = ^v[i*DCF_BYTE_BITS +: 8] ^ o;
    end
    return v;
  endfunction : gen
  task automatic check(input dcf_word_type seen, input dcf_word_type exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic flag(input logic s, input logic x1);
    check({35'h0, s}, {35'h0, x1});
  endtask : flag
  // One request held for exactly one taking edge, then released.
  task automatic op(input logic on_b, input logic wr, input logic mail,
                    input logic g, input dcf_word_type d);
    @(posedge clock_in);
    if (on_b) begin
      b_req <= '{1'b0, wr, 1'b1, mail, g};
      b_drv <= d;
    end else begin
      a_ctl <= '{1'b0, wr, 1'b1, mail, g};
      a_drv <= d;
    end
    @(posedge clock_in);
    a_ctl <= idle_ctl;
    b_req <= idle_ctl;
  endtask : op
  task automatic waitc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : waitc
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      x = 16 - 4 * k; // Presets 16, 12, 8 and 4 for selects 0 to 3.
      odd <= k[0];
      offset_sel_in <= k[1:0];
      rst_in <= 1'b1;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      for (int n = 1; n <= 65; n++) begin
        seed = lfsr(seed);
        w = {seed[3:0], seed};
        op(1'b0, 1'b1, 1'b0, seed[4], w);
        if (n <= 64) q.push_back(w);
        waitc(1);
        flag(pea, gen(w, k[0]) === w);
        waitc(1);
        if (n == x + 1) flag(ae, 1'b0);
        waitc(1);
        flag(ae, q.size() > x);
        flag(af, q.size() < 64 - x);
        flag(ff, q.size() < 64);
      end
      while (q.size() > 0) begin
        seed = lfsr(seed);
        op(1'b1, 1'b0, 1'b0, seed[0], '0);
        e = seed[0] ? gen(q.pop_front(), k[0]) : q.pop_front();
        waitc(1);
        check(b_out, e);
        waitc(1);
        if (q.size() == 63 - x) flag(af, 1'b0);
        waitc(1);
        flag(af, q.size() < 64 - x);
        flag(ef, q.size() > 0);
      end
      op(1'b1, 1'b0, 1'b0, 1'b0, '0);
      waitc(1);
      check(b_out, e);
      $display("offset test %0d done", k);
    end
    seed = lfsr(seed);
    w = {seed[3:0], seed};
    op(1'b0, 1'b1, 1'b1, 1'b1, w);
    #1 flag(mf1, 1'b0);
    op(1'b0, 1'b1, 1'b1, 1'b0, ~w);
    op(1'b1, 1'b0, 1'b1, 1'b0, '0);
    #1 check(b_out, w);
    flag(mf1, 1'b1);
    flag(b_oe, 1'b1);
    op(1'b1, 1'b0, 1'b1, 1'b1, '0);
    #1 check(b_out, gen(w, odd));
    op(1'b1, 1'b0, 1'b1, 1'b0, '0);
    #1 check(b_out, w);
    op(1'b1, 1'b1, 1'b1, 1'b0, ~w);
    #1 flag(mf2, 1'b0);
    flag(peb, gen(~w, odd) === ~w);
    op(1'b0, 1'b0, 1'b1, 1'b0, '0);
    #1 check(a_out, ~w);
    flag(mf2, 1'b1);
    flag(a_oe, 1'b1);
    op(1'b0, 1'b0, 1'b1, 1'b1, '0);
    #1 check(a_out, gen(~w, odd));
    flag(pea, 1'b1);
    $display("mailbox test done");
    print_verdict();
  end
endmodule : dual_clock_fifo_flags_mail_parity_tb
